//--- design/gpp_pad_par.sv
// One pad parameter register with write-once drive fields.
// Assumes wr is a one-cycle pulse with wdata valid in that cycle.
`timescale 1ns/100ps
`default_nettype none
module gpp_pad_par #(
    parameter int unsigned PORT = 0
) (
    // Clock and reset
    input  wire logic  clk_i,
    input  wire logic  rst_i,
    // Register access
    gpp_par_if.regs    par
);
    import gpp_pkg::*;

    localparam logic [31:0] PUD_M = GPP_PUD_MASK[PORT];
    localparam logic [31:0] DRV_M = GPP_DRV_MASK[PORT];
    localparam gpp_par_state_t ST_RST = '{
        par:        GPP_PAR_RST[PORT] & (PUD_M | DRV_M),
        drv_locked: 1'h0};

    gpp_par_state_t st_ff;
    gpp_par_state_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (par.wr) begin
            // Fixed and reserved bits stay zero
            nxt_st.par = (st_ff.par & ~PUD_M) | (par.wdata & PUD_M);
            if (!st_ff.drv_locked) begin
                nxt_st.par = (nxt_st.par & ~DRV_M) | (par.wdata & DRV_M);
                nxt_st.drv_locked = 1'h1;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_ff <= ST_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign par.rdata = st_ff.par;
endmodule // gpp_pad_par
`default_nettype wire

//--- design/gpp_port.sv
// GPIO data, set, clear and pad parameter logic for three 8-pin ports.
// Assumes pins synchronous to clk_i and one AHB-Lite master.
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module gpp_port (
    // Clock and reset
    input  wire logic                                  clk_i,
    input  wire logic                                  rst_i,
    // AHB-Lite slave
    input  wire logic                                  hsel_i,
    input  wire logic [31:0]                           haddr_i,
    input  wire logic [1:0]                            htrans_i,
    input  wire logic                                  hwrite_i,
    input  wire logic [2:0]                            hsize_i,
    input  wire logic [31:0]                           hwdata_i,
    input  wire logic                                  hready_i,
    output logic                                       hreadyout_o,
    output logic                                       hresp_o,
    output logic [31:0]                                hrdata_o,
    // Pins
    input  wire logic [gpp_pkg::GPP_PORTS-1:0][7:0]    pin_i,
    output logic [gpp_pkg::GPP_PORTS-1:0][7:0]         pin_o,
    output logic [gpp_pkg::GPP_PORTS-1:0][7:0]         pin_oe_o,
    // Pad controls
    input  wire logic                                  analog_input_twelve_sel_i,
    output logic [gpp_pkg::GPP_PORTS-1:0][7:0]         pullup_en_o,
    output logic [gpp_pkg::GPP_PORTS-1:0][7:0]         drive_low_o,
    output logic [gpp_pkg::GPP_PORTS-1:0][7:0]         drive_high_o
);
    import gpp_pkg::*;

    localparam gpp_state_t ST_RST = '{
        bus:         GPP_BUS_IDLE,
        hready:      1'h1,
        hresp:       GPP_HRESP_OKAY,
        wr_kind:     GPP_K_DAT,
        pad_applied: {GPP_PAR_RST[2] & (GPP_PUD_MASK[2] | GPP_DRV_MASK[2]),
                      GPP_PAR_RST[1] & (GPP_PUD_MASK[1] | GPP_DRV_MASK[1]),
                      GPP_PAR_RST[0] & (GPP_PUD_MASK[0] | GPP_DRV_MASK[0])},
        pu_en:       {(GPP_PORTS*8){1'h1}},
        default:     '0};

    gpp_state_t st_ff;
    gpp_state_t nxt_st;

    logic [GPP_PORTS-1:0]       par_wr;
    logic [GPP_PORTS-1:0][31:0] par_rd;

    // Address lookup: {hit, port, kind}
    function automatic logic [4:0] gpp_decode(input logic [31:0] addr);
        gpp_decode = '0;
        for (int p = 0; p < GPP_PORTS; p++) begin
            for (int k = 0; k < 4; k++) begin
                if (addr == GPP_REG_ADDR[p][k]) begin
                    gpp_decode = {1'h1, 2'(p), 2'(k)};
                end
            end
        end
    endfunction

    // Pad parameter registers
    for (genvar g = 0; g < GPP_PORTS; g++) begin : g_par
        gpp_par_if par_if ();
        assign par_if.wr    = par_wr[g];
        assign par_if.wdata = hwdata_i;
        assign par_rd[g]    = par_if.rdata;
        gpp_pad_par #(
            .PORT (g)
        ) u_par (
            .clk_i (clk_i),
            .rst_i (rst_i),
            .par   (par_if)
        );
    end

    always_comb begin
        logic [4:0] dec;
        logic [1:0] dp;
        logic [1:0] hl;
        dec    = '0;
        dp     = '0;
        hl     = '0;
        nxt_st = st_ff;
        par_wr = '0;

        // Live pin levels in every pin mode
        nxt_st.din = pin_i;

        // Levels caught once, first edge after reset release
        if (!st_ff.captured) begin
            nxt_st.captured = 1'h1;
            nxt_st.rst_lvl  = pin_i;
        end

        unique case (st_ff.bus)
            GPP_BUS_IDLE: begin
                nxt_st.hready = 1'h1;
                if (hsel_i && htrans_i[1] && hready_i) begin
                    dec = gpp_decode(haddr_i);
                    dp  = dec[3:2];
                    if (hwrite_i) begin
                        nxt_st.bus     = GPP_BUS_WR;
                        nxt_st.hready  = 1'h0;
                        nxt_st.wr_hit  = dec[4];
                        nxt_st.wr_port = dp;
                        nxt_st.wr_kind = gpp_kind_t'(dec[1:0]);
                    end else begin
                        nxt_st.rdata = '0;
                        if (dec[4]) begin
                            unique case (gpp_kind_t'(dec[1:0]))
                                GPP_K_DAT: nxt_st.rdata = {st_ff.dir[dp], st_ff.dout[dp],
                                                           st_ff.rst_lvl[dp], st_ff.din[dp]};
                                GPP_K_SET: nxt_st.rdata = '0;
                                GPP_K_CLR: nxt_st.rdata = '0;
                                GPP_K_PAR: nxt_st.rdata = par_rd[dp];
                            endcase
                        end
                    end
                end
            end
            GPP_BUS_WR: begin
                // Data phase: hwdata valid, one wait state
                nxt_st.bus    = GPP_BUS_IDLE;
                nxt_st.hready = 1'h1;
                dp = st_ff.wr_port;
                if (st_ff.wr_hit) begin
                    unique case (st_ff.wr_kind)
                        GPP_K_DAT: begin
                            nxt_st.dir[dp]  = hwdata_i[GPP_DIR_LSB +: 8];
                            nxt_st.dout[dp] = hwdata_i[GPP_OUT_LSB +: 8];
                            // Pad settings take effect here
                            nxt_st.pad_applied[dp] = par_rd[dp];
                        end
                        GPP_K_SET: begin
                            nxt_st.dout[dp] = st_ff.dout[dp]
                                            | hwdata_i[GPP_OUT_LSB +: 8];
                        end
                        GPP_K_CLR: begin
                            nxt_st.dout[dp] = st_ff.dout[dp]
                                            & ~hwdata_i[GPP_OUT_LSB +: 8];
                        end
                        GPP_K_PAR: par_wr[dp] = 1'h1;
                    endcase
                end
            end
        endcase

        // Pad controls from the applied parameters
        for (int p = 0; p < GPP_PORTS; p++) begin
            for (int n = 0; n < GPP_PINS; n++) begin
                nxt_st.pu_en[p][n] =
                    !st_ff.pad_applied[p][n*GPP_GRP_W+GPP_PUD_OFS];
                hl = gpp_drv_decode(st_ff.pad_applied[p], n);
                nxt_st.drv_high[p][n] = hl[1];
                nxt_st.drv_low[p][n]  = hl[0];
            end
        end
        if (analog_input_twelve_sel_i) begin
            nxt_st.pu_en[2][0] = 1'h1;
        end
        nxt_st.hresp = GPP_HRESP_OKAY;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_ff <= ST_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign hreadyout_o  = st_ff.hready;
    assign hresp_o      = st_ff.hresp;
    assign hrdata_o     = st_ff.rdata;
    assign pin_o        = st_ff.dout;
    assign pin_oe_o     = st_ff.dir;
    assign pullup_en_o  = st_ff.pu_en;
    assign drive_low_o  = st_ff.drv_low;
    assign drive_high_o = st_ff.drv_high;
endmodule // gpp_port
`default_nettype wire

//--- inc/gpp_par_if.sv
// Link between the port logic and one pad parameter register.
// Assumes a single clock shared by both ends.
`timescale 1ns/100ps
`default_nettype none
interface gpp_par_if;
    logic        wr;
    logic [31:0] wdata;
    logic [31:0] rdata;

    modport ctrl (output wr, output wdata, input rdata);
    modport regs (input wr, input wdata, output rdata);
endinterface
`default_nettype wire

//--- inc/gpp_pkg.sv
// Constants, types and helpers shared by the GPIO port block.
// Assumes a 40 MHz system clock and a word-wide AHB-Lite register bus.
package gpp_pkg;

    localparam int unsigned GPP_PORTS = 3;
    localparam int unsigned GPP_PINS  = 8;

    // Register byte addresses
    localparam logic [31:0] GPP_PORT0_DIR_DATA_ADDR   = 32'hFFFFF420;
    localparam logic [31:0] GPP_PORT0_BIT_SET_ADDR    = 32'hFFFFF424;
    localparam logic [31:0] GPP_PORT0_BIT_CLEAR_ADDR  = 32'hFFFFF428;
    localparam logic [31:0] GPP_PORT0_PAD_PARAMS_ADDR = 32'hFFFFF42C;
    localparam logic [31:0] GPP_PORT1_DIR_DATA_ADDR   = 32'hFFFFF430;
    localparam logic [31:0] GPP_PORT1_BIT_SET_ADDR    = 32'hFFFFF434;
    localparam logic [31:0] GPP_PORT1_BIT_CLEAR_ADDR  = 32'hFFFFF438;
    localparam logic [31:0] GPP_PORT1_PAD_PARAMS_ADDR = 32'hFFFFF43C;
    localparam logic [31:0] GPP_PORT2_DIR_DATA_ADDR   = 32'hFFFFF440;
    localparam logic [31:0] GPP_PORT2_BIT_SET_ADDR    = 32'hFFFFF444;
    localparam logic [31:0] GPP_PORT2_BIT_CLEAR_ADDR  = 32'hFFFFF448;
    localparam logic [31:0] GPP_PORT2_PAD_PARAMS_ADDR = 32'hFFFFF44C;

    typedef enum logic [1:0] {
        GPP_K_DAT = 2'h0,
        GPP_K_SET = 2'h1,
        GPP_K_CLR = 2'h2,
        GPP_K_PAR = 2'h3
    } gpp_kind_t;

    localparam logic [31:0] GPP_REG_ADDR [GPP_PORTS][4] = '{
        '{GPP_PORT0_DIR_DATA_ADDR, GPP_PORT0_BIT_SET_ADDR,
          GPP_PORT0_BIT_CLEAR_ADDR, GPP_PORT0_PAD_PARAMS_ADDR},
        '{GPP_PORT1_DIR_DATA_ADDR, GPP_PORT1_BIT_SET_ADDR,
          GPP_PORT1_BIT_CLEAR_ADDR, GPP_PORT1_PAD_PARAMS_ADDR},
        '{GPP_PORT2_DIR_DATA_ADDR, GPP_PORT2_BIT_SET_ADDR,
          GPP_PORT2_BIT_CLEAR_ADDR, GPP_PORT2_PAD_PARAMS_ADDR}};

    // Data register field positions
    localparam int unsigned GPP_DIR_LSB = 24;
    localparam int unsigned GPP_OUT_LSB = 16;
    localparam int unsigned GPP_RST_LSB = 8;
    localparam int unsigned GPP_IN_LSB  = 0;

    // Pad parameter layout
    localparam int unsigned GPP_GRP_W   = 4;
    localparam int unsigned GPP_PUD_OFS = 0;
    localparam int unsigned GPP_DRV_OFS = 1;
    localparam logic [1:0]  GPP_DRV_MED = 2'h0;
    localparam logic [1:0]  GPP_DRV_LOW = 2'h1;

    // Writable pull-up disable bits per port
    localparam logic [31:0] GPP_PUD_MASK [GPP_PORTS] = '{
        32'h11111111, 32'h11111111, 32'h00011100};
    // Writable drive strength bits per port
    localparam logic [31:0] GPP_DRV_MASK [GPP_PORTS] = '{
        32'h66600000, 32'h66000000, 32'h00000000};
    // Pad parameter reset words
    localparam logic [31:0] GPP_PAR_RST [GPP_PORTS] = '{
        32'h22220000, 32'h22000022, 32'h00000000};

    // AHB-Lite codes
    localparam logic [1:0] GPP_HTRANS_NONSEQ = 2'h2;
    localparam logic       GPP_HRESP_OKAY    = 1'h0;

    typedef enum logic {
        GPP_BUS_IDLE = 1'h0,
        GPP_BUS_WR   = 1'h1
    } gpp_bus_st_t;

    typedef struct packed {
        gpp_bus_st_t                bus;
        logic                       hready;
        logic                       hresp;
        logic [31:0]                rdata;
        logic                       wr_hit;
        logic [1:0]                 wr_port;
        gpp_kind_t                  wr_kind;
        logic                       captured;
        logic [GPP_PORTS-1:0][7:0]  dir;
        logic [GPP_PORTS-1:0][7:0]  dout;
        logic [GPP_PORTS-1:0][7:0]  rst_lvl;
        logic [GPP_PORTS-1:0][7:0]  din;
        logic [GPP_PORTS-1:0][31:0] pad_applied;
        logic [GPP_PORTS-1:0][7:0]  pu_en;
        logic [GPP_PORTS-1:0][7:0]  drv_low;
        logic [GPP_PORTS-1:0][7:0]  drv_high;
    } gpp_state_t;

    typedef struct packed {
        logic [31:0] par;
        logic        drv_locked;
    } gpp_par_state_t;

    // Drive code of pin n: returns {high, low}
    function automatic logic [1:0] gpp_drv_decode(input logic [31:0] par,
                                                  input int unsigned pin);
        logic [1:0] code;
        code = par[pin*GPP_GRP_W+GPP_DRV_OFS +: 2];
        gpp_drv_decode = {code[1], code == GPP_DRV_LOW};
    endfunction

endpackage

//--- tb/gpp_pins_model.sv
// Board model: pins driven by the block, by the board or by pull-ups.
// Assumes block outputs change just after a rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module gpp_pins_model (
    // Clock
    input  wire logic            clk_i,
    // Block side
    input  wire logic [2:0][7:0] pin_o,
    input  wire logic [2:0][7:0] pin_oe_o,
    input  wire logic [2:0][7:0] pullup_en_o,
    // Board side
    input  wire logic [2:0][7:0] ext_i,
    input  wire logic [2:0][7:0] ext_en_i,
    output logic      [2:0][7:0] pin_i
);
    // Floating pin without pull-up toggles each cycle
    logic tog_ff = 1'b0;
    always_ff @(posedge clk_i) tog_ff <= ~tog_ff;
    assign pin_i = (pin_oe_o & pin_o) | (~pin_oe_o & ext_en_i & ext_i)
                 | (~pin_oe_o & ~ext_en_i & (pullup_en_o | {24{tog_ff}}));
endmodule // gpp_pins_model
`default_nettype wire

//--- tb/gpp_port_chk.sv
// Checker of the GPIO port block's pin and pad outputs.
// Assumes it is bound to gpp_port and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module gpp_port_chk (
    // Clock and reset
    input wire logic            clk_i,
    input wire logic            rst_i,
    // Bus and pins
    input wire logic            hreadyout_o,
    input wire logic            hresp_o,
    input wire logic [2:0][7:0] pin_o,
    input wire logic [2:0][7:0] pin_oe_o,
    // Pads
    input wire logic            analog_input_twelve_sel_i,
    input wire logic [2:0][7:0] pullup_en_o,
    input wire logic [2:0][7:0] drive_low_o,
    input wire logic [2:0][7:0] drive_high_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_okay; hresp_o == 1'h0; endproperty
    a_okay: assert property (p_okay) else $error("hresp not OKAY");
    property p_dir; $changed(pin_oe_o) |-> !$past(hreadyout_o); endproperty
    a_dir: assert property (p_dir) else $error("direction moved outside write");
    property p_out; $changed(pin_o) |-> !$past(hreadyout_o); endproperty
    a_out: assert property (p_out) else $error("output moved outside write");
    property p_rst; $fell(rst_i) |-> pin_oe_o == 24'h0 && pin_o == 24'h0; endproperty
    a_rst: assert property (p_rst) else $error("pins not inputs after reset");
    property p_ana; analog_input_twelve_sel_i |=> pullup_en_o[2][0]; endproperty
    a_ana: assert property (p_ana) else $error("analog pin pull-up off");
    property p_drv; (drive_low_o & drive_high_o) == 24'h0; endproperty
    a_drv: assert property (p_drv) else $error("low and high drive together");
    property p_fix; ((drive_low_o | drive_high_o) & ~24'h00C0E0) == 24'h0; endproperty
    a_fix: assert property (p_fix) else $error("fixed drive pin not medium");
    property p_p2pu; (pullup_en_o[2] & 8'hE3) == 8'hE3; endproperty
    a_p2pu: assert property (p_p2pu) else $error("port2 fixed pull-up off");
endmodule // gpp_port_chk
bind gpp_port gpp_port_chk u_chk (.clk_i, .rst_i, .hreadyout_o, .hresp_o, .pin_o,
    .pin_oe_o, .analog_input_twelve_sel_i, .pullup_en_o, .drive_low_o, .drive_high_o);
`default_nettype wire

//--- tb/tb_top.sv
// Testbench of the GPIO port block: AHB-Lite tasks, board model, scenarios.
// Assumes the checker is bound from its own file.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import gpp_pkg::*;
    localparam logic [2:0][7:0] EXT0 = 24'h3C96A1;
    logic            clk_i = 1'b0;
    logic            rst_i = 1'b1;
    logic            hsel_i = 1'b0;
    logic            hwrite_i = 1'b0;
    logic            ana_sel = 1'b0;
    logic [1:0]      htrans_i = 2'h0;
    logic [31:0]     haddr_i = 32'h0;
    logic [31:0]     hwdata_i = 32'h0;
    logic [2:0][7:0] ext = EXT0;
    logic [2:0][7:0] ext_en = 24'hFFFFFF;
    logic            hreadyout_o, hresp_o;
    logic [31:0]     hrdata_o, r;
    logic [2:0][7:0] pin_i, pin_o, pin_oe_o, pullup_en_o, drive_low_o, drive_high_o;
    int              bad_count = 0;
    int              num_checks = 0;
    initial forever #12.5 clk_i = ~clk_i;
    gpp_port uut (.clk_i, .rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i(3'h2),
        .hwdata_i, .hready_i(hreadyout_o), .hreadyout_o, .hresp_o, .hrdata_o, .pin_i,
        .pin_o, .pin_oe_o, .analog_input_twelve_sel_i(ana_sel), .pullup_en_o,
        .drive_low_o, .drive_high_o);
    gpp_pins_model board (.clk_i, .pin_o, .pin_oe_o, .pullup_en_o, .ext_i(ext),
        .ext_en_i(ext_en), .pin_i);
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wt;
        int n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (hreadyout_o !== 1'b1 && n < 50);
        if (hreadyout_o !== 1'b1) begin
            bad_count++;
            end_of_test();
        end
    endtask
    task automatic xfer(logic [31:0] a, logic w, logic [31:0] d);
        hsel_i <= 1'b1;
        haddr_i <= a;
        htrans_i <= GPP_HTRANS_NONSEQ;
        hwrite_i <= w;
        wt();
        hsel_i <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= d;
        wt();
        r = hrdata_o;
    endtask
    task automatic rc(string n, logic [31:0] a, logic [31:0] e);
        xfer(a, 1'b0, 32'h0);
        chk(n, e, r);
    endtask
    function automatic logic [31:0] ad(int p, gpp_kind_t k);
        return GPP_REG_ADDR[p][k];
    endfunction
    task automatic t_reset;
        for (int p = 0; p < 3; p++) begin
            rc("dat_rst", ad(p, GPP_K_DAT), {16'h0, EXT0[p], EXT0[p]});
        end
        rc("par0_rst", ad(0, GPP_K_PAR), 32'h22200000);
        rc("par1_rst", ad(1, GPP_K_PAR), 32'h22000000);
        rc("par2_rst", ad(2, GPP_K_PAR), 32'h0);
        chk("oe_rst", 32'h0, 32'(pin_oe_o));
    endtask
    task automatic t_data;
        ext[1] <= 8'h69;
        xfer(ad(1, GPP_K_DAT), 1'b1, 32'hA55AFFFF);
        @(posedge clk_i);
        chk("oe1", 32'hA5, 32'(pin_oe_o[1]));
        chk("out1", 32'h5A, 32'(pin_o[1]));
        rc("dat1", ad(1, GPP_K_DAT), {16'hA55A, 8'h96, 8'h5A & 8'hA5 | 8'h69 & ~8'hA5});
    endtask
    task automatic t_setclr;
        for (int p = 0; p < 3; p++) begin
            xfer(ad(p, GPP_K_DAT), 1'b1, 32'h000F0000);
            xfer(ad(p, GPP_K_SET), 1'b1, 32'hFF30FFFF);
            xfer(ad(p, GPP_K_CLR), 1'b1, 32'hFF0CFFFF);
            rc("dat_sc", ad(p, GPP_K_DAT), {16'h0033, EXT0[p], ext[p]});
            rc("set_rd", ad(p, GPP_K_SET), 32'h0);
            rc("clr_rd", ad(p, GPP_K_CLR), 32'h0);
        end
        xfer(32'hFFFFF450, 1'b1, 32'hFFFFFFFF);
        rc("unmapped", 32'hFFFFF450, 32'h0);
    endtask
    task automatic t_pad;
        xfer(ad(1, GPP_K_PAR), 1'b1, 32'h43000000);
        rc("par1", ad(1, GPP_K_PAR), 32'h43000000);
        chk("drl1_old", 32'hC0, 32'(drive_low_o[1]));
        xfer(ad(1, GPP_K_DAT), 1'b1, 32'h0);
        @(posedge clk_i);
        chk("drh1", 32'h80, 32'(drive_high_o[1]));
        chk("drl1", 32'h40, 32'(drive_low_o[1]));
        chk("pu1", 32'hBF, 32'(pullup_en_o[1]));
        xfer(ad(1, GPP_K_PAR), 1'b1, 32'h66000000);
        rc("par1_lock", ad(1, GPP_K_PAR), 32'h42000000);
        xfer(ad(0, GPP_K_PAR), 1'b1, 32'hFFFFFFFF);
        rc("par0", ad(0, GPP_K_PAR), 32'h77711111);
        xfer(ad(2, GPP_K_PAR), 1'b1, 32'hFFFFFFFF);
        rc("par2", ad(2, GPP_K_PAR), 32'h00011100);
        xfer(ad(2, GPP_K_DAT), 1'b1, 32'h0);
        @(posedge clk_i);
        chk("pu2", 32'hE3, 32'(pullup_en_o[2]));
        ana_sel <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk("pu2_ana", 32'hE3, 32'(pullup_en_o[2]));
    endtask
    // Mid-run reset: new capture, drive fields writable once more
    task automatic t_rerun;
        ext[0] <= 8'h5A;
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rc("dat0_rerun", ad(0, GPP_K_DAT), {16'h0, 8'h5A, 8'h5A});
        rc("par1_rerun_rst", ad(1, GPP_K_PAR), 32'h22000000);
        xfer(ad(1, GPP_K_PAR), 1'b1, 32'h66000000);
        rc("par1_rerun", ad(1, GPP_K_PAR), 32'h66000000);
        xfer(ad(1, GPP_K_PAR), 1'b1, 32'h22000000);
        rc("par1_relock", ad(1, GPP_K_PAR), 32'h66000000);
    endtask
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_data();
        t_setclr();
        t_pad();
        t_rerun();
        end_of_test();
    end
endmodule // tb_top
`default_nettype wire
